//--- bench/core_model.sv
// core sequencer model: acknowledges requests, tracks stack depth
`timescale 1ns/100ps
module core_model
  import irq_ctrl_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_b_i,
  input  wire logic           irq_req_i,
  input  wire vector_cmd_type vector_cmd_i,
  input  wire logic [3:0]     ack_delay_i,
  output logic                core_ack_o,
  output logic [4:0]          depth_o
);
  logic [3:0] wait_cnt;

  // a slow core lets the request stand before taking it
  assign core_ack_o = irq_req_i && (wait_cnt >= ack_delay_i);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) wait_cnt <= 4'h0;
    else if (!irq_req_i || core_ack_o) wait_cnt <= 4'h0;
    else wait_cnt <= wait_cnt + 4'h1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) depth_o <= 5'h00;
    else if (vector_cmd_i.push) depth_o <= depth_o + 5'h01;
    else if (vector_cmd_i.pop) depth_o <= depth_o - 5'h01;
  end
endmodule

//--- bench/tb.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
module tb;
  import irq_ctrl_pkg::*;
  logic           clk = 1'b0;
  logic           rst_b = 1'b0;
  logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0, prdata, rd;
  logic           pready, pslverr, se, irq_req, gdis, ack;
  logic           ext_pin = 1'b0, t0pin = 1'b0, t0ovf = 1'b0;
  logic           two_cyc = 1'b0, ret = 1'b0, hz = 1'b0;
  logic [7:0]     ev1 = 8'h00, ev2 = 8'h00;
  logic [15:0]    evs;
  logic [3:0]     ack_delay = 4'h0;
  logic [4:0]     depth;
  vector_cmd_type vcmd;
  int             err_count = 0, samples_checked = 0;

  always #5 clk = ~clk;

  vectored_interrupt_control vectored_interrupt_control_i (
    .clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr),
    .ext_irq_pin_i(ext_pin), .timer0_clock_pin_i(t0pin),
    .timer0_overflow_i(t0ovf), .periph_event_one_i(ev1),
    .periph_event_two_i(ev2), .serial_level_one_i(2'b01),
    .serial_level_two_i(2'b10), .core_ack_i(ack),
    .return_from_irq_instr_i(ret), .two_cycle_instr_i(two_cyc),
    .irq_req_o(irq_req), .vector_cmd_o(vcmd),
    .global_irq_disable_o(gdis));

  core_model core_model_i (
    .clk_i(clk), .rst_b_i(rst_b), .irq_req_i(irq_req),
    .vector_cmd_i(vcmd), .ack_delay_i(ack_delay),
    .core_ack_o(ack), .depth_o(depth));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, d);
    int   n = 0;
    logic ok;
    // a release still pending in this step needs one idle cycle
    if (psel) @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // hazard test lines the timer pulse up with the write edge
    if (hz) t0ovf <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      ok = pready;
      rd = prdata;
      se = pslverr;
    end while (ok !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (hz) t0ovf <= 1'b0;
    if (ok !== 1'b1) begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, e);
    xfer(1'b0, a, 8'h00);
    chk(what, rd, {24'h0, e});
  endtask

  task automatic wait_vec(input logic [15:0] a, input logic p);
    int n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (vcmd.load !== 1'b1 && n < 40);
    if (vcmd.load !== 1'b1) begin
      err_count++;
      end_sim();
    end
    chk("vector", vcmd.addr, a);
    chk("push", vcmd.push, p);
    if (p) chk("disable", gdis, 1'b1);
    @(posedge clk);
  endtask

  task automatic pulse_ret;
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    @(negedge clk);
    chk("pop", vcmd.pop, 1'b1);
    chk("disable", gdis, 1'b0);
    @(posedge clk);
  endtask

  task automatic idle_chk(input int c, input logic e);
    repeat (c) @(posedge clk);
    @(negedge clk);
    chk("req", irq_req, e);
    @(posedge clk);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk("core", 8'h1c, 8'h00);
    rdchk("en1", 8'h5c, 8'h00);
    rdchk("en2", 8'h44, 8'h00);
    wr(8'h1c, 8'hff);
    rdchk("core", 8'h1c, 8'h7f);
    wr(8'h5c, 8'hff);
    rdchk("en1", 8'h5c, 8'hff);
    rdchk("core", 8'h1c, 8'hff);
    wr(8'h44, 8'hff);
    rdchk("en2", 8'h44, 8'hef);
    // enables cleared only while globally disabled
    wr(8'h5c, 8'h00);
    wr(8'h44, 8'h00);
    wr(8'h1c, 8'h00);
    xfer(1'b0, 8'hfc, 8'h00);
    chk("slverr", se, 1'b1);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      evs = 16'h0001 << i;
      {ev2, ev1} <= evs;
      @(posedge clk);
      {ev2, ev1} <= 16'h0000;
      rdchk("fl1", 8'h58, evs[7:0] & 8'hfc | 8'h01);
      rdchk("fl2", 8'h40, evs[15:8] & 8'hec | 8'h02);
      wr(8'h58, 8'h00);
      wr(8'h40, 8'h00);
    end
    $display("test peripheral flags done");
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h03);
    wr(8'h1c, 8'h01);
    two_cyc <= 1'b1;
    ext_pin <= 1'b1;
    idle_chk(8, 1'b0);
    rdchk("core", 8'h1c, 8'h11);
    two_cyc <= 1'b0;
    wait_vec(16'h0008, 1'b1);
    rdchk("core", 8'h1c, 8'h01);
    chk("depth", depth, 5'h01);
    pulse_ret;
    $display("test external pin done");
    wr(8'h1c, 8'h02);
    chk("depth", depth, 5'h00);
    hz = 1'b1;
    wr(8'h1c, 8'h00);
    hz = 1'b0;
    wait_vec(16'h0000, 1'b0);
    wr(8'h04, 8'h10);
    wr(8'h1c, 8'h00);
    $display("test enable hazard done");
    wr(8'h5c, 8'h80);
    // enables first: writing zero flag bits would wipe the events
    wr(8'h1c, 8'h06);
    ev1 <= 8'h80;
    t0ovf <= 1'b1;
    t0pin <= 1'b1;
    @(posedge clk);
    ev1 <= 8'h00;
    t0ovf <= 1'b0;
    // pin edge needs the synchroniser before the flag shows
    repeat (2) @(posedge clk);
    rdchk("core", 8'h1c, 8'he6);
    ack_delay <= 4'h3;
    wr(8'h04, 8'h00);
    wait_vec(16'h0010, 1'b1);
    pulse_ret;
    wait_vec(16'h0018, 1'b1);
    rdchk("core", 8'h1c, 8'h86);
    pulse_ret;
    idle_chk(6, 1'b0);
    wr(8'h1c, 8'h0e);
    wait_vec(16'h0020, 1'b1);
    rdchk("fl1", 8'h58, 8'h81);
    wr(8'h58, 8'h00);
    rdchk("core", 8'h1c, 8'h0e);
    pulse_ret;
    idle_chk(6, 1'b0);
    chk("depth", depth, 5'h00);
    wr(8'h08, 8'h00);
    ext_pin <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk("core", 8'h1c, 8'h1e);
    $display("test priority done");
    end_sim();
  end
endmodule

//--- verilog/irq_ctrl_pkg.sv
// constants, types and register map of the vectored interrupt controller
// Contract
// - eighteen interrupt sources are accepted
// - taking an interrupt disables, pushes, loads vector
// - four vectors, peripherals share one
// - non-peripheral vectoring clears serviced flag
// - peripheral vectoring leaves peripheral flags alone
// - flags set regardless of enables
// - two-cycle instruction may add one cycle
// - return instruction pops and re-enables
// - bit 7 is read-only enabled peripheral OR
// - pending peripheral vectors to 20h
// - bit 6 timer0 pin flag, cleared at 18h
// - bit 5 timer0 overflow flag, cleared at 10h
// - bit 4 external pin flag, cleared at 08h
// - flag set while enable cleared goes to 00h
// - bit 3 gates all peripheral requests
// - bits 2..0 are core source enables
// - core register at 07h, resets to zero
// - enable register one at 17h layout
// - enable register two at 11h layout
// - fixed priority ext, ovf, pin, peripherals
// - flag register one at 16h mirrors enables
// - flag register two at 10h, bit 4 zero
package irq_ctrl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CPU_STATUS = 6'h01;
  localparam logic [5:0] IDX_EDGE_CTRL  = 6'h02;
  localparam logic [5:0] IDX_CORE       = 6'h07;
  localparam logic [5:0] IDX_FLAGS_TWO  = 6'h10;
  localparam logic [5:0] IDX_ENABLE_TWO = 6'h11;
  localparam logic [5:0] IDX_FLAGS_ONE  = 6'h16;
  localparam logic [5:0] IDX_ENABLE_ONE = 6'h17;
  // core register fields
  localparam int BIT_PERIPH_PEND = 7;
  localparam int BIT_T0PIN_FLAG  = 6;
  localparam int BIT_T0OV_FLAG   = 5;
  localparam int BIT_EXT_FLAG    = 4;
  localparam int BIT_PERIPH_EN   = 3;
  localparam int BIT_T0PIN_EN    = 2;
  localparam int BIT_T0OV_EN     = 1;
  localparam int BIT_EXT_EN      = 0;
  // cpu status and edge control fields
  localparam int BIT_GLOBAL_DIS  = 4;
  localparam int BIT_EXT_RISING  = 0;
  localparam int BIT_T0P_RISING  = 1;
  // reset values
  localparam logic [7:0] CORE_RESET   = 8'h00;
  localparam logic [7:0] PERIPH_RESET = 8'h00;
  localparam logic [7:0] EDGE_RESET   = 8'h00;
  localparam logic       GID_RESET    = 1'b1;
  // writable masks; low two flag bits follow serial hardware levels
  localparam logic [7:0] FLAGS_ONE_WMASK  = 8'hfc;
  localparam logic [7:0] FLAGS_TWO_WMASK  = 8'hec;
  localparam logic [7:0] ENABLE_TWO_WMASK = 8'hef;
  // vector addresses
  localparam logic [15:0] VEC_RESET  = 16'h0000;
  localparam logic [15:0] VEC_EXT    = 16'h0008;
  localparam logic [15:0] VEC_T0OV   = 16'h0010;
  localparam logic [15:0] VEC_T0PIN  = 16'h0018;
  localparam logic [15:0] VEC_PERIPH = 16'h0020;

  typedef enum {SRC_NONE, SRC_EXT, SRC_T0OV, SRC_T0PIN, SRC_PERIPH}
    src_type;

  typedef struct packed {
    logic        load;
    logic        push;
    logic        pop;
    logic [15:0] addr;
  } vector_cmd_type;
endpackage

//--- verilog/pin_edge_detect.sv
// two-flop synchroniser with selectable edge detection for one pin
`timescale 1ns/100ps
module pin_edge_detect (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  input  wire logic rising_i,
  output logic      edge_o
);
  logic       meta;
  logic       sync;
  logic       last;
  logic [1:0] warm;

  // meta feeds only sync
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else if (ce_i) begin
      meta <= pin_i;
      sync <= meta;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last <= 1'b0;
    end else if (ce_i) begin
      last <= sync;
    end
  end

  // pin may idle high; no edge until the chain holds real history
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warm <= 2'h0;
    end else if (ce_i && warm != 2'h3) begin
      warm <= warm + 2'h1;
    end
  end

  // one-cycle pulse on the chosen edge
  assign edge_o = (warm == 2'h3) &
                  (rising_i ? (sync & ~last) : (~sync & last));
endmodule

//--- verilog/vectored_interrupt_control.sv
// vectored interrupt controller with apb register access
`timescale 1ns/100ps
module vectored_interrupt_control
  import irq_ctrl_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                ce_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [ADDR_W-1:0]   paddr_i,
  input  wire logic [DATA_W-1:0]   pwdata_i,
  output logic      [DATA_W-1:0]   prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic                ext_irq_pin_i,
  input  wire logic                timer0_clock_pin_i,
  input  wire logic                timer0_overflow_i,
  input  wire logic [7:0]          periph_event_one_i,
  input  wire logic [7:0]          periph_event_two_i,
  input  wire logic [1:0]          serial_level_one_i,
  input  wire logic [1:0]          serial_level_two_i,
  input  wire logic                core_ack_i,
  input  wire logic                return_from_irq_instr_i,
  input  wire logic                two_cycle_instr_i,
  output logic                     irq_req_o,
  output vector_cmd_type           vector_cmd_o,
  output logic                     global_irq_disable_o
);
  logic       rst_meta;
  logic       rst_n;
  logic       ext_edge;
  logic       t0pin_edge;
  logic [7:0] edge_ctrl;
  logic [2:0] core_flags;
  logic [3:0] core_en;
  logic [7:0] flags_one_q;
  logic [7:0] flags_two_q;
  logic [7:0] flags_one;
  logic [7:0] flags_two;
  logic [7:0] enable_one;
  logic [7:0] enable_two;
  logic       global_irq_disable;
  logic       periph_pending;
  logic       periph_set_now;
  logic [2:0] core_set;
  logic [2:0] vec_clear;
  logic [7:0] core_read;
  logic [7:0] ev_one;
  logic [7:0] ev_two;
  logic [5:0] idx;
  logic       addr_ok;
  logic       hit;
  logic       wr_en;
  logic       wr_core;
  logic [7:0] wbyte;
  logic       data_ready;
  logic [7:0] read_byte;
  logic       hazard_now;
  logic       take;
  logic       return_from_irq_instr;
  src_type    sel;
  logic [15:0] sel_vec;

  // reset asserts at once, releases after two clean edges
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // pin sources pass the synchroniser before edge logic
  pin_edge_detect u_ext_edge (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n),
    .ce_i     (ce_i),
    .pin_i    (ext_irq_pin_i),
    .rising_i (edge_ctrl[BIT_EXT_RISING]),
    .edge_o   (ext_edge)
  );

  pin_edge_detect u_t0pin_edge (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n),
    .ce_i     (ce_i),
    .pin_i    (timer0_clock_pin_i),
    .rising_i (edge_ctrl[BIT_T0P_RISING]),
    .edge_o   (t0pin_edge)
  );

  // apb decode; only whole aligned words at the seven mapped indices
  assign idx     = paddr_i[7:2];
  assign addr_ok = (paddr_i[1:0] == 2'b00);
  always_comb begin
    case (idx)
      IDX_CPU_STATUS, IDX_EDGE_CTRL, IDX_CORE, IDX_FLAGS_TWO,
      IDX_ENABLE_TWO, IDX_FLAGS_ONE, IDX_ENABLE_ONE: hit = addr_ok;
      default: hit = 1'b0;
    endcase
  end
  assign wr_en     = psel_i & penable_i & pwrite_i & pready_o & hit;
  assign wr_core   = wr_en & (idx == IDX_CORE);
  assign wbyte     = pwdata_i[7:0];
  assign pready_o  = ce_i & penable_i & data_ready;
  assign pslverr_o = psel_i & penable_i & ~hit;

  // event sources; serial bits are levels, not events
  assign ev_one   = periph_event_one_i & FLAGS_ONE_WMASK;
  assign ev_two   = periph_event_two_i & FLAGS_TWO_WMASK;
  assign core_set = {t0pin_edge, timer0_overflow_i, ext_edge};

  assign flags_one = {flags_one_q[7:2], serial_level_one_i};
  assign flags_two = {flags_two_q[7:2], serial_level_two_i};

  // summary bit counts enabled peripherals only
  assign periph_pending = |(flags_one & enable_one) |
                          |(flags_two & enable_two);
  assign periph_set_now = |(ev_one & enable_one) | |(ev_two & enable_two);

  // fixed priority among enabled sources
  always_comb begin
    if (core_flags[0] & core_en[BIT_EXT_EN]) begin
      sel = SRC_EXT;
    end else if (core_flags[1] & core_en[BIT_T0OV_EN]) begin
      sel = SRC_T0OV;
    end else if (core_flags[2] & core_en[BIT_T0PIN_EN]) begin
      sel = SRC_T0PIN;
    end else if (periph_pending & core_en[BIT_PERIPH_EN]) begin
      sel = SRC_PERIPH;
    end else begin
      sel = SRC_NONE;
    end
  end

  always_comb begin
    case (sel)
      SRC_EXT:    sel_vec = VEC_EXT;
      SRC_T0OV:   sel_vec = VEC_T0OV;
      SRC_T0PIN:  sel_vec = VEC_T0PIN;
      SRC_PERIPH: sel_vec = VEC_PERIPH;
      default:    sel_vec = VEC_RESET;
    endcase
  end

  // second cycle of a two-cycle instruction holds the request back
  assign irq_req_o = ~global_irq_disable & (sel != SRC_NONE) &
                     ~two_cycle_instr_i;
  assign take      = ce_i & irq_req_o & core_ack_i;
  assign return_from_irq_instr    = ce_i & return_from_irq_instr_i;

  // flag set together with its enable being cleared
  assign hazard_now = wr_core & ~global_irq_disable &
    (|(core_set & core_en[2:0] & ~wbyte[2:0]) |
     (periph_set_now & core_en[BIT_PERIPH_EN] &
      ~wbyte[BIT_PERIPH_EN]));

  // only dedicated vectors clear their own flag
  always_comb begin
    vec_clear = 3'b000;
    if (take) begin
      case (sel)
        SRC_EXT:   vec_clear = 3'b001;
        SRC_T0OV:  vec_clear = 3'b010;
        SRC_T0PIN: vec_clear = 3'b100;
        default:   vec_clear = 3'b000;
      endcase
    end
  end

  // core flags: a new event beats any clear
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      core_flags <= CORE_RESET[BIT_T0PIN_FLAG:BIT_EXT_FLAG];
    end else if (ce_i) begin
      if (wr_core) begin
        core_flags <= core_set |
          wbyte[BIT_T0PIN_FLAG:BIT_EXT_FLAG];
      end else begin
        core_flags <= core_set | (core_flags & ~vec_clear);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      core_en <= CORE_RESET[BIT_PERIPH_EN:BIT_EXT_EN];
    end else if (ce_i && wr_core) begin
      core_en <= wbyte[BIT_PERIPH_EN:BIT_EXT_EN];
    end
  end

  // peripheral flags untouched by vectoring, only events and writes
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_one_q <= PERIPH_RESET;
      flags_two_q <= PERIPH_RESET;
    end else if (ce_i) begin
      if (wr_en && idx == IDX_FLAGS_ONE) begin
        flags_one_q <= ev_one | (wbyte & FLAGS_ONE_WMASK);
      end else begin
        flags_one_q <= ev_one | (flags_one_q & FLAGS_ONE_WMASK);
      end
      if (wr_en && idx == IDX_FLAGS_TWO) begin
        flags_two_q <= ev_two | (wbyte & FLAGS_TWO_WMASK);
      end else begin
        flags_two_q <= ev_two | (flags_two_q & FLAGS_TWO_WMASK);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      enable_one <= PERIPH_RESET;
      enable_two <= PERIPH_RESET;
    end else if (ce_i && wr_en) begin
      if (idx == IDX_ENABLE_ONE) begin
        enable_one <= wbyte;
      end
      if (idx == IDX_ENABLE_TWO) begin
        enable_two <= wbyte & ENABLE_TWO_WMASK;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      edge_ctrl <= EDGE_RESET;
    end else if (ce_i && wr_en && idx == IDX_EDGE_CTRL) begin
      edge_ctrl <= wbyte;
    end
  end

  // taking beats return beats software in the same cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_disable <= GID_RESET;
    end else if (ce_i) begin
      if (take) begin
        global_irq_disable <= 1'b1;
      end else if (return_from_irq_instr) begin
        global_irq_disable <= 1'b0;
      end else if (wr_en && idx == IDX_CPU_STATUS) begin
        global_irq_disable <= wbyte[BIT_GLOBAL_DIS];
      end
    end
  end
  assign global_irq_disable_o = global_irq_disable;

  // commands to the core sequencer, one-cycle pulses
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vector_cmd_o <= '0;
    end else if (ce_i) begin
      vector_cmd_o.load <= 1'b0;
      vector_cmd_o.push <= 1'b0;
      vector_cmd_o.pop  <= return_from_irq_instr;
      if (hazard_now) begin
        vector_cmd_o.load <= 1'b1;
        vector_cmd_o.addr <= VEC_RESET;
      end else if (take) begin
        vector_cmd_o.load <= 1'b1;
        vector_cmd_o.push <= 1'b1;
        vector_cmd_o.addr <= sel_vec;
      end
    end
  end

  // read value of the core register
  assign core_read = {periph_pending, core_flags, core_en};

  always_comb begin
    case (idx)
      IDX_CPU_STATUS: read_byte = 8'(global_irq_disable) << BIT_GLOBAL_DIS;
      IDX_EDGE_CTRL:  read_byte = edge_ctrl;
      IDX_CORE:       read_byte = core_read;
      IDX_FLAGS_TWO:  read_byte = flags_two;
      IDX_ENABLE_TWO: read_byte = enable_two;
      IDX_FLAGS_ONE:  read_byte = flags_one;
      IDX_ENABLE_ONE: read_byte = enable_one;
      default:        read_byte = 8'h00;
    endcase
  end

  // read data captured a cycle early so it comes from a flop
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_ready <= 1'b0;
      prdata_o   <= '0;
    end else if (ce_i) begin
      data_ready <= psel_i & ~(penable_i & data_ready);
      if (psel_i && !(penable_i && data_ready)) begin
        prdata_o <= {24'h000000, (hit ? read_byte : 8'h00)};
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  property p_take_ext;
    take && sel == SRC_EXT && !hazard_now |=> vector_cmd_o.load &&
      vector_cmd_o.push && vector_cmd_o.addr == VEC_EXT && global_irq_disable;
  endproperty
  a_take_ext: assert property (p_take_ext)
    else $error("external vector not issued");

  property p_take_periph;
    take && sel == SRC_PERIPH && !hazard_now |=>
      vector_cmd_o.addr == VEC_PERIPH && vector_cmd_o.push;
  endproperty
  a_take_periph: assert property (p_take_periph)
    else $error("peripheral vector not issued");

  property p_gid_set;
    take |=> global_irq_disable_o ##1 !irq_req_o;
  endproperty
  a_gid_set: assert property (p_gid_set)
    else $error("disable not set on vectoring");

  property p_return_from_irq_instr;
    return_from_irq_instr && !take |=> !global_irq_disable_o && vector_cmd_o.pop;
  endproperty
  a_return_from_irq_instr: assert property (p_return_from_irq_instr)
    else $error("return did not re-enable");

  property p_ovf_clear;
    take && sel == SRC_T0OV && !timer0_overflow_i && !wr_core |=>
      !core_flags[1];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow flag not cleared");

  property p_periph_keep;
    take && sel == SRC_PERIPH && !wr_en |=>
      flags_one_q == ($past(flags_one_q) | $past(ev_one)) &&
      flags_two_q == ($past(flags_two_q) | $past(ev_two));
  endproperty
  a_periph_keep: assert property (p_periph_keep)
    else $error("peripheral flags changed by vectoring");

  property p_ext_sets;
    ce_i && ext_edge |=> core_flags[0];
  endproperty
  a_ext_sets: assert property (p_ext_sets)
    else $error("external flag missed its edge");

  property p_hazard;
    hazard_now |=> vector_cmd_o.load && vector_cmd_o.addr == VEC_RESET &&
      !vector_cmd_o.push;
  endproperty
  a_hazard: assert property (p_hazard)
    else $error("hazard did not vector to reset");

  property p_gate;
    global_irq_disable_o || two_cycle_instr_i |-> !irq_req_o;
  endproperty
  a_gate: assert property (p_gate)
    else $error("request while blocked");

  property p_periph_group;
    !core_en[BIT_PERIPH_EN] |-> sel != SRC_PERIPH;
  endproperty
  a_periph_group: assert property (p_periph_group)
    else $error("peripheral selected while group disabled");
endmodule
